/* File: design/iel_error_logger.sv */
// iel_error_logger: i/o bus error logs, error config and status/control.
// assumes error events arrive as one-cycle strobes on this clock and the
// register port is a simple same-clock read/write strobe interface.
//
// Operation
// - smart/dumb bit one selects smart handling, zero selects dumb handling
// - error code replaced only by a strictly more severe error
// - fatal, uncorrected, corrected detect flags set when that class occurs
// - per-class repeat flags at bits 44, 43, 42 on second error
// - hard-fail setting captured when first or most severe error logs
// - smart setting captured when first or most severe error logs
// - writing both log-clear bits in status/control clears the status log
// - owner, inbound address, type, outbound address follow error code overwrite
// - dumb-mode address parity raises system error, counted as second fatal
// - legacy overflow set when fatal logged and another fatal arrives
// - legacy overflow set on second uncorrected with no fatal logged
// - legacy overflow stays clear across mixed uncorrected and single fatal
// - bus owner log is one-hot, valid only after owner-logging errors
// - owner bits map slots a to f; agp only a; pci-x never f
// - bridge self position in owner log is never set
// - upper inbound address bits forced zero without dual-address cycle
// - pci zeroes inbound address bits 1:0; pci-x keeps those two bits
// - inbound type flags: dma read, dma write, peer write, msi
// - pci-x attribute phase captured into the type log only on pci-x
// - bus reset function bit holds the bus in reset until cleared
`timescale 1ns/10ps
module iel_error_logger #(
  parameter int unsigned BRST_MIN_CYC = iel_pkg::IEL_BUS_RST_MIN_CYC
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // register port
  input  wire logic                reg_rd,
  input  wire logic                reg_wr,
  input  wire logic [11:0]         reg_addr,
  input  wire logic [63:0]         reg_wdata,
  output logic [63:0]              reg_rdata,
  output logic                     reg_rvalid,
  // bus context
  input  iel_pkg::iel_bus_t        bus_mode,
  // error event
  input  wire logic                err_valid,
  input  iel_pkg::iel_sev_t        err_sev,
  input  wire logic [7:0]          err_code,
  input  wire logic                err_apar,
  input  wire logic                err_log_master,
  input  wire logic [5:0]          err_master_req,
  input  wire logic                err_log_inbound,
  input  wire logic                in_dac,
  input  wire logic [63:0]         in_addr,
  input  wire logic [3:0]          in_type,
  input  wire logic [31:0]         in_attr,
  input  wire logic                err_log_outbound,
  input  wire logic [63:0]         out_addr,
  // bus side outputs
  output logic                     bus_serr_req,
  output logic                     bus_reset_func
);
  import iel_pkg::*;

  typedef struct packed {
    logic        smart;
    logic        fail_rsp;
    logic        brst;
    logic [16:0] brst_cnt;
    logic        brst_met;
    iel_sev_t    sev;
    logic [7:0]  code;
    logic [2:0]  det;
    logic [2:0]  rep;
    logic        leg_rep;
    logic        fail_snap;
    logic        s_snap;
    logic [63:0] in_addr_log;
    logic [63:0] in_type_log;
    logic [63:0] owner_log;
    logic [63:0] out_addr_log;
    logic        serr;
    logic [63:0] rdata;
    logic        rvalid;
  } iel_state_t;

  iel_state_t state_ff;
  iel_state_t nxt_state;

  logic        ctl_wr;
  logic        log_wipe;
  logic        apar_dumb;
  iel_sev_t    base_sev;
  logic [2:0]  base_det;
  logic [2:0]  base_rep;
  logic        base_leg;
  iel_sev_t    eff_sev;
  logic        overwrite;
  logic [2:0]  merged_det;
  logic [2:0]  merged_rep;
  logic        merged_leg;
  logic [63:0] fmt_addr;
  logic [63:0] fmt_type;
  logic [63:0] fmt_owner;

  // status word as software sees it; unnamed bits read zero
  function automatic logic [63:0] status_word(input iel_state_t s);
    logic [63:0] w;
    w = '0;
    w[IEL_ST_CODE_LSB +: 8] = s.code;
    w[IEL_ST_LEGACY_REP]    = s.leg_rep;
    w[IEL_ST_FATAL]         = s.det[2];
    w[IEL_ST_NONCORR]       = s.det[1];
    w[IEL_ST_FIXED]         = s.det[0];
    w[IEL_ST_FAIL_SNAP]     = s.fail_snap;
    w[IEL_ST_S_SNAP]        = s.s_snap;
    w[IEL_ST_FIXED_REP]     = s.rep[0];
    w[IEL_ST_NONC_REP]      = s.rep[1];
    w[IEL_ST_FATAL_REP]     = s.rep[2];
    return w;
  endfunction : status_word

  // wipe needs both clear bits so a stray single-bit write cannot lose a log
  assign ctl_wr    = reg_wr && (reg_addr == IEL_OFF_CTL);
  assign log_wipe  = ctl_wr && reg_wdata[IEL_CTL_WIPE] && reg_wdata[IEL_CTL_WIPE2];
  assign apar_dumb = err_valid && err_apar && !state_ff.smart;

  // wipe is applied first so an event in the same cycle still lands
  assign base_sev = log_wipe ? IEL_SEV_NONE : state_ff.sev;
  assign base_det = log_wipe ? 3'b000 : state_ff.det;
  assign base_rep = log_wipe ? 3'b000 : state_ff.rep;
  assign base_leg = log_wipe ? 1'b0 : state_ff.leg_rep;

  iel_sev_merge u_merge (
    .logged_sev (base_sev),
    .class_det  (base_det),
    .class_rep  (base_rep),
    .legacy_rep (base_leg),
    .evt_valid  (err_valid),
    .evt_sev    (err_sev),
    .apar_dumb  (apar_dumb),
    .eff_sev    (eff_sev),
    .overwrite  (overwrite),
    .merged_det (merged_det),
    .merged_rep (merged_rep),
    .merged_leg (merged_leg)
  );

  iel_inbound_fmt u_fmt (
    .bus_mode   (bus_mode),
    .in_dac     (in_dac),
    .in_addr    (in_addr),
    .in_type    (in_type),
    .in_attr    (in_attr),
    .master_req (err_master_req),
    .fmt_addr   (fmt_addr),
    .fmt_type   (fmt_type),
    .fmt_owner  (fmt_owner)
  );

  // next state: register writes, wipe, event merge, reset hold, read mux
  always_comb begin
    nxt_state        = state_ff;
    nxt_state.serr   = 1'b0;
    nxt_state.rvalid = 1'b0;
    if (reg_wr && (reg_addr == IEL_OFF_CFG)) begin
      nxt_state.smart = reg_wdata[IEL_CFG_SMART];
    end
    if (ctl_wr) begin
      nxt_state.fail_rsp = reg_wdata[IEL_CTL_FAIL];
      nxt_state.brst     = reg_wdata[IEL_CTL_BRST];
    end
    if (log_wipe) begin
      nxt_state.code         = 8'h00;
      nxt_state.fail_snap    = 1'b0;
      nxt_state.s_snap       = 1'b0;
      nxt_state.in_addr_log  = '0;
      nxt_state.in_type_log  = '0;
      nxt_state.owner_log    = '0;
      nxt_state.out_addr_log = '0;
    end
    nxt_state.sev = base_sev;
    nxt_state.det = merged_det;
    nxt_state.rep = merged_rep;
    nxt_state.leg_rep = merged_leg;
    // every correlated log moves only together with the code
    if (overwrite) begin
      nxt_state.sev          = eff_sev;
      nxt_state.code         = err_code;
      nxt_state.fail_snap    = state_ff.fail_rsp;
      nxt_state.s_snap       = state_ff.smart;
      nxt_state.owner_log    = err_log_master ? fmt_owner : '0;
      nxt_state.in_addr_log  = err_log_inbound ? fmt_addr : '0;
      nxt_state.in_type_log  = err_log_inbound ? fmt_type : '0;
      nxt_state.out_addr_log = err_log_outbound ? out_addr : '0;
    end
    nxt_state.serr = apar_dumb;
    // status only: the hold time is software's job, this just reports it
    if (!nxt_state.brst || !state_ff.brst) begin
      nxt_state.brst_cnt = 17'h0_0000;
      nxt_state.brst_met = 1'b0;
    end else if (!state_ff.brst_met) begin
      nxt_state.brst_cnt = state_ff.brst_cnt + 17'h0_0001;
      nxt_state.brst_met = (nxt_state.brst_cnt >= 17'(BRST_MIN_CYC));
    end
    if (reg_rd) begin
      nxt_state.rvalid = 1'b1;
      case (reg_addr)
        IEL_OFF_CFG:      nxt_state.rdata = {63'h0, state_ff.smart};
        IEL_OFF_CTL:      nxt_state.rdata = {59'h0, state_ff.brst_met, state_ff.brst,
                                             state_ff.fail_rsp, 2'b00};
        IEL_OFF_STATUS:   nxt_state.rdata = status_word(state_ff);
        IEL_OFF_OWNER:    nxt_state.rdata = state_ff.owner_log;
        IEL_OFF_IN_ADDR:  nxt_state.rdata = state_ff.in_addr_log;
        IEL_OFF_IN_TYPE:  nxt_state.rdata = state_ff.in_type_log;
        IEL_OFF_OUT_ADDR: nxt_state.rdata = state_ff.out_addr_log;
        default:          nxt_state.rdata = '0;
      endcase
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff       <= '0;
      state_ff.smart <= IEL_CFG_SMART_RST;
      state_ff.fail_rsp <= IEL_CTL_FAIL_RST;
      state_ff.brst     <= IEL_CTL_BRST_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata      = state_ff.rdata;
  assign reg_rvalid     = state_ff.rvalid;
  assign bus_serr_req   = state_ff.serr;
  assign bus_reset_func = state_ff.brst;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_smart_apar: assert property (
    (err_valid && err_apar && state_ff.smart) |=> !bus_serr_req)
    else $error("smart mode raised system error on address parity");

  chk_code_kept: assert property (
    (err_valid && !err_apar && !log_wipe && (err_sev <= state_ff.sev))
    |=> $stable(state_ff.code) && $stable(state_ff.owner_log))
    else $error("log changed on equal or lower severity");

  chk_fatal_flag: assert property (
    (err_valid && err_sev == IEL_SEV_FATAL) |=> state_ff.det[2])
    else $error("fatal detect flag not set");

  chk_unc_repeat: assert property (
    (err_valid && !err_apar && err_sev == IEL_SEV_UNC && state_ff.det[1] && !log_wipe)
    |=> state_ff.rep[1])
    else $error("uncorrected repeat flag not set");

  chk_fail_capture: assert property (
    overwrite |=> (state_ff.fail_snap == $past(state_ff.fail_rsp)))
    else $error("hard-fail snapshot wrong");

  chk_s_capture: assert property (
    overwrite |=> (state_ff.s_snap == $past(state_ff.smart)))
    else $error("smart snapshot wrong");

  chk_wipe_clears: assert property (
    (log_wipe && !err_valid) |=> (status_word(state_ff) == 64'h0000_0000_0000_0000))
    else $error("status log not cleared by wipe");

  chk_serr_fatal: assert property (
    (err_valid && err_apar && !state_ff.smart)
    |=> (bus_serr_req && state_ff.rep[2]) ##1 (!bus_serr_req || $past(apar_dumb)))
    else $error("address parity in dumb mode mishandled");

  chk_legacy_fatal: assert property (
    (err_valid && err_sev == IEL_SEV_FATAL && state_ff.sev == IEL_SEV_FATAL && !log_wipe)
    |=> state_ff.leg_rep)
    else $error("overflow missed on second fatal");

  chk_legacy_mixed: assert property (
    (state_ff.sev == IEL_SEV_UNC && !state_ff.leg_rep && err_valid && !err_apar &&
     err_sev == IEL_SEV_FATAL && !log_wipe) |=> !state_ff.leg_rep)
    else $error("overflow set by first fatal after uncorrected");

  chk_owner_self: assert property (
    !state_ff.owner_log[IEL_MID_SELF])
    else $error("bridge self position set in owner log");

  chk_agp_owner: assert property (
    (overwrite && bus_mode == IEL_BUS_AGP) |=> (state_ff.owner_log[63:2] == 62'h0))
    else $error("agp owner log holds a slot other than a");

  chk_addr_upper: assert property (
    (overwrite && err_log_inbound && !in_dac) |=> (state_ff.in_addr_log[63:32] == 32'h0))
    else $error("upper inbound address not zeroed");

  chk_reset_hold: assert property (
    (state_ff.brst && !ctl_wr) |=> bus_reset_func)
    else $error("bus reset dropped without a write");

endmodule : iel_error_logger

/* File: design/iel_pkg.sv */
// iel_pkg: constants and types shared by the i/o bus error logger.
// assumes a 64-bit register port with 12-bit byte offsets, one clock.
package iel_pkg;

  // register byte offsets
  localparam logic [11:0] IEL_OFF_OUT_ADDR  = 12'h070;
  localparam logic [11:0] IEL_OFF_CTL       = 12'h040;
  localparam logic [11:0] IEL_OFF_IN_ADDR   = 12'h290;
  localparam logic [11:0] IEL_OFF_IN_TYPE   = 12'h298;
  localparam logic [11:0] IEL_OFF_CFG       = 12'h680;
  localparam logic [11:0] IEL_OFF_STATUS    = 12'h688;
  localparam logic [11:0] IEL_OFF_OWNER     = 12'h690;

  // fault_response_config fields
  localparam int IEL_CFG_SMART = 0;

  // status_info_control_reg fields
  localparam int IEL_CTL_WIPE     = 0;
  localparam int IEL_CTL_WIPE2    = 1;
  localparam int IEL_CTL_FAIL     = 2;
  localparam int IEL_CTL_BRST     = 3;
  localparam int IEL_CTL_BRST_MET = 4;

  // fault_status_log fields
  localparam int IEL_ST_CODE_LSB  = 56;
  localparam int IEL_ST_LEGACY_REP = 55;
  localparam int IEL_ST_FATAL     = 54;
  localparam int IEL_ST_NONCORR   = 53;
  localparam int IEL_ST_FIXED     = 52;
  localparam int IEL_ST_FAIL_SNAP = 51;
  localparam int IEL_ST_S_SNAP    = 50;
  localparam int IEL_ST_FIXED_REP = 44;
  localparam int IEL_ST_NONC_REP  = 43;
  localparam int IEL_ST_FATAL_REP = 42;

  // fault_bus_owner_log fields: bit 0 is the bridge itself, 1..6 slots a..f
  localparam int IEL_MID_SELF   = 0;
  localparam int IEL_MID_SLOT_A = 1;

  // inbound_fault_type_log fields
  localparam int IEL_TY_ATTR_LSB = 32;

  // reset values
  localparam logic IEL_CFG_SMART_RST = 1'b0;
  localparam logic IEL_CTL_FAIL_RST  = 1'b0;
  localparam logic IEL_CTL_BRST_RST  = 1'b1;

  // minimum i/o bus reset time
  localparam int IEL_CLK_PERIOD_NS   = 8;
  localparam int IEL_BUS_RST_MIN_NS  = 1000000;
  localparam int IEL_BUS_RST_MIN_CYC =
    (IEL_BUS_RST_MIN_NS + IEL_CLK_PERIOD_NS - 1) / IEL_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    IEL_SEV_NONE  = 2'b00,
    IEL_SEV_CORR  = 2'b01,
    IEL_SEV_UNC   = 2'b10,
    IEL_SEV_FATAL = 2'b11
  } iel_sev_t;

  typedef enum logic [1:0] {
    IEL_BUS_PCI  = 2'b00,
    IEL_BUS_AGP  = 2'b01,
    IEL_BUS_PCIX = 2'b10
  } iel_bus_t;

endpackage : iel_pkg

/* File: design/iel_sev_merge.sv */
// iel_sev_merge: folds one error event into the severity flags.
// assumes the caller has already applied any log wipe to its inputs.
`timescale 1ns/10ps
module iel_sev_merge (
  // logged state
  input  iel_pkg::iel_sev_t logged_sev,
  input  wire logic [2:0]   class_det,
  input  wire logic [2:0]   class_rep,
  input  wire logic         legacy_rep,
  // incoming event
  input  wire logic         evt_valid,
  input  iel_pkg::iel_sev_t evt_sev,
  input  wire logic         apar_dumb,
  // merged result
  output iel_pkg::iel_sev_t eff_sev,
  output logic              overwrite,
  output logic [2:0]        merged_det,
  output logic [2:0]        merged_rep,
  output logic              merged_leg
);
  import iel_pkg::*;

  // a dumb-mode address parity error is fatal whatever its source said
  assign eff_sev   = apar_dumb ? IEL_SEV_FATAL : evt_sev;
  // only a strictly higher severity takes over the log
  assign overwrite = evt_valid && (eff_sev > logged_sev);

  // one detect and repeat pair per class, class g has severity g+1
  for (genvar g = 0; g < 3; g++) begin : g_cls
    logic hit;
    assign hit = evt_valid && (eff_sev == iel_sev_t'(2'(g + 1)));
    assign merged_det[g] = class_det[g] | hit;
    // the system-error the bridge raises counts as a second fatal
    assign merged_rep[g] = class_rep[g] |
                           (hit && (class_det[g] || (apar_dumb && g == 2)));
  end

  // legacy overflow: a repeat of the highest class logged, unc or fatal only
  assign merged_leg = legacy_rep |
                      (evt_valid && (eff_sev >= IEL_SEV_UNC) &&
                       ((eff_sev == logged_sev) || apar_dumb));

endmodule : iel_sev_merge

/* File: design/iel_inbound_fmt.sv */
// iel_inbound_fmt: shapes inbound address, type and bus owner log words.
// assumes bus mode and request lines come from logic on the same clock.
`timescale 1ns/10ps
module iel_inbound_fmt (
  // bus context
  input  iel_pkg::iel_bus_t bus_mode,
  // inbound transaction
  input  wire logic         in_dac,
  input  wire logic [63:0]  in_addr,
  input  wire logic [3:0]   in_type,
  input  wire logic [31:0]  in_attr,
  input  wire logic [5:0]   master_req,
  // formatted log words
  output logic [63:0]       fmt_addr,
  output logic [63:0]       fmt_type,
  output logic [63:0]       fmt_owner
);
  import iel_pkg::*;

  // true when exactly one bit is set
  function automatic logic is_onehot(input logic [5:0] v);
    return (v != 6'h00) && ((v & (v - 6'h01)) == 6'h00);
  endfunction : is_onehot

  logic [5:0] slot_mask;
  logic [5:0] slots;

  // agp has only the graphics master, pci-x never uses slot f
  always_comb begin
    case (bus_mode)
      IEL_BUS_AGP:  slot_mask = 6'h01;
      IEL_BUS_PCIX: slot_mask = 6'h1f;
      default:      slot_mask = 6'h3f;
    endcase
  end

  assign slots = master_req & slot_mask;

  // one-hot or nothing; the bridge position stays clear
  always_comb begin
    fmt_owner = '0;
    if (is_onehot(slots)) begin
      fmt_owner[IEL_MID_SLOT_A +: 6] = slots;
    end
    fmt_owner[IEL_MID_SELF] = 1'b0;
  end

  // single-address cycles carry no upper half; pci drops byte bits
  assign fmt_addr[63:32] = in_dac ? in_addr[63:32] : 32'h0000_0000;
  assign fmt_addr[31:2]  = in_addr[31:2];
  assign fmt_addr[1:0]   = (bus_mode == IEL_BUS_PCIX) ? in_addr[1:0] : 2'b00;

  // type flags low, attribute phase high and only on pci-x
  always_comb begin
    fmt_type = '0;
    fmt_type[3:0] = in_type;
    if (bus_mode == IEL_BUS_PCIX) begin
      fmt_type[IEL_TY_ATTR_LSB +: 32] = in_attr;
    end
  end

endmodule : iel_inbound_fmt

/* File: test/iel_bus_agent.sv */
// iel_bus_agent: behavioural i/o bus side, watches system-error requests and bus reset.
// assumes it shares the logger's clock and synchronous reset.
`timescale 1ns/10ps
module iel_bus_agent (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // bus side of the logger
  input  wire logic        bus_serr_req,
  input  wire logic        bus_reset_func,
  // observation
  output logic [15:0]      serr_cnt,
  output logic [15:0]      rst_cyc
);
  // every serr pulse counts as one system error seen on the bus
  always @(posedge clk) begin
    if (rst) begin
      serr_cnt <= 16'h0;
      rst_cyc  <= 16'h0;
    end else begin
      if (bus_serr_req === 1'b1) serr_cnt <= serr_cnt + 16'h1;
      // a held bus reset keeps the agents quiet, counted for visibility
      rst_cyc <= (bus_reset_func === 1'b1) ? rst_cyc + 16'h1 : 16'h0;
    end
  end
endmodule : iel_bus_agent

/* File: test/tb_top.sv */
// tb_top: self-checking bench for the error logger; reads are checked from a queue.
// assumes the bus agent model and a shortened bus reset hold time.
`timescale 1ns/10ps
module tb_top;
  import iel_pkg::*;
  localparam int unsigned BRST_MIN = 8;
  typedef struct packed { logic [63:0] e; logic [63:0] m; } iel_note_t;
  logic        clk, rst, reg_rd, reg_wr, reg_rvalid, bus_serr_req, bus_reset_func;
  logic        err_valid, err_apar, err_log_master, err_log_inbound, in_dac;
  logic        err_log_outbound;
  logic [11:0] reg_addr;
  logic [63:0] reg_wdata, reg_rdata, in_addr, out_addr, a, o;
  logic [7:0]  err_code;
  logic [5:0]  err_master_req;
  logic [3:0]  in_type;
  logic [31:0] in_attr, at;
  logic [15:0] serr_cnt, rst_cyc;
  iel_bus_t    bus_mode;
  iel_sev_t    err_sev;
  iel_note_t   notes[$];
  iel_note_t   nt;
  integer      seed = 32'h2eaf_2671;
  int          n_mismatch = 0;
  int          comparisons = 0;

  iel_error_logger #(.BRST_MIN_CYC(BRST_MIN)) i_iel_error_logger (
    .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .bus_mode(bus_mode), .err_valid(err_valid), .err_sev(err_sev), .err_code(err_code),
    .err_apar(err_apar), .err_log_master(err_log_master), .err_master_req(err_master_req),
    .err_log_inbound(err_log_inbound), .in_dac(in_dac), .in_addr(in_addr),
    .in_type(in_type), .in_attr(in_attr), .err_log_outbound(err_log_outbound),
    .out_addr(out_addr), .bus_serr_req(bus_serr_req), .bus_reset_func(bus_reset_func));

  iel_bus_agent i_iel_bus_agent (
    .clk(clk), .rst(rst), .bus_serr_req(bus_serr_req), .bus_reset_func(bus_reset_func),
    .serr_cnt(serr_cnt), .rst_cyc(rst_cyc));

  // 125 mhz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // status word: code, {legacy, fatal, noncorr, fixed, fail, smart}, {fixed, noncorr, fatal} repeats
  function automatic logic [63:0] st(input logic [7:0] c, input logic [5:0] hi,
                                     input logic [2:0] rep);
    return {c, hi, 5'h0, rep, 42'h0};
  endfunction : st

  task automatic cmp(input logic [63:0] g, input logic [63:0] e, input logic [63:0] m);
    comparisons++;
    if ((g & m) !== (e & m)) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g & m, e & m);
    end
  endtask : cmp

  task automatic wr(input logic [11:0] ad, input logic [63:0] d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = ad;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  // the expected word is queued when the read is launched
  task automatic rd(input logic [11:0] ad, input logic [63:0] e, input logic [63:0] m = '1);
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = ad;
    notes.push_back('{e: e, m: m});
    @(negedge clk);
    reg_rd = 1'b0;
  endtask : rd

  // one error event; logging requests follow from which fields are given
  task automatic ev(input iel_sev_t s, input logic [7:0] c, input logic ap = 1'b0,
                    input iel_bus_t bm = IEL_BUS_PCI, input logic [5:0] rq = 6'h0,
                    input logic dac = 1'b0, input logic [63:0] ia = 64'h0,
                    input logic [3:0] ty = 4'h0, input logic [63:0] oa = 64'h0);
    @(negedge clk);
    err_valid        = 1'b1;
    err_sev          = s;
    err_code         = c;
    err_apar         = ap;
    bus_mode         = bm;
    err_master_req   = rq;
    err_log_master   = |rq;
    in_dac           = dac;
    in_addr          = ia;
    in_type          = ty;
    in_attr          = $random(seed);
    err_log_inbound  = (|ia) | (|ty);
    out_addr         = oa;
    err_log_outbound = |oa;
    @(negedge clk);
    err_valid = 1'b0;
  endtask : ev

  task automatic wp();
    wr(IEL_OFF_CTL, 64'h3);
  endtask : wp

  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // result watcher: each read answer takes the oldest note off the queue
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (notes.size() == 0) begin
        n_mismatch++;
        $display("unexpected at %0t: got %h expected %h", $time, reg_rdata, 64'h0);
      end else begin
        nt = notes.pop_front();
        cmp(reg_rdata, nt.e, nt.m);
      end
    end
  end

  // watchdog sized well above the scripted sequence length
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {rst, reg_rd, reg_wr, err_valid, err_apar, err_log_master} = 6'h20;
    {err_log_inbound, in_dac, err_log_outbound} = 3'h0;
    reg_addr = 12'h0;
    reg_wdata = 64'h0;
    bus_mode = IEL_BUS_PCI;
    err_sev = IEL_SEV_NONE;
    {err_code, err_master_req, in_type, in_attr, in_addr, out_addr} = '0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    cmp(bus_reset_func, 64'h1, 64'h1);
    rd(IEL_OFF_CFG, 64'h0);
    rd(IEL_OFF_STATUS, 64'h0);
    rd(IEL_OFF_CTL, 64'h8, 64'h1f);
    repeat (BRST_MIN + 2) @(negedge clk);
    rd(IEL_OFF_CTL, 64'h18, 64'h1f);
    wr(IEL_OFF_CTL, 64'h0);
    @(negedge clk);
    cmp(bus_reset_func, 64'h0, 64'h1);
    wr(IEL_OFF_CTL, 64'h8);
    @(negedge clk);
    cmp(bus_reset_func, 64'h1, 64'h1);
    repeat (BRST_MIN + 2) @(negedge clk);
    cmp(rst_cyc >= BRST_MIN, 64'h1, 64'h1);
    wp();
    // smart mode severity ladder
    wr(IEL_OFF_CFG, 64'h1);
    rd(IEL_OFF_CFG, 64'h1);
    ev(IEL_SEV_CORR, 8'h11);
    ev(IEL_SEV_CORR, 8'h12);
    rd(IEL_OFF_STATUS, st(8'h11, 6'b000101, 3'b100));
    ev(IEL_SEV_UNC, 8'h13);
    ev(IEL_SEV_FATAL, 8'h14);
    ev(IEL_SEV_UNC, 8'h15);
    rd(IEL_OFF_STATUS, st(8'h14, 6'b011101, 3'b110));
    wp();
    rd(IEL_OFF_STATUS, 64'h0);
    ev(IEL_SEV_UNC, 8'h16);
    ev(IEL_SEV_UNC, 8'h17);
    rd(IEL_OFF_STATUS, st(8'h16, 6'b101001, 3'b010));
    wp();
    ev(IEL_SEV_FATAL, 8'h21, 1'b1);
    ev(IEL_SEV_FATAL, 8'h22);
    rd(IEL_OFF_STATUS, st(8'h21, 6'b110001, 3'b001));
    cmp(serr_cnt, 64'h0, 64'hffff);
    // dumb mode address parity with hard-fail set
    wp();
    wr(IEL_OFF_CFG, 64'h0);
    wr(IEL_OFF_CTL, 64'h4);
    ev(IEL_SEV_FATAL, 8'h31, 1'b1);
    rd(IEL_OFF_STATUS, st(8'h31, 6'b110010, 3'b001));
    cmp(serr_cnt, 64'h1, 64'hffff);
    // correlated logs
    wp();
    a = {$random(seed), $random(seed)};
    o = {$random(seed), $random(seed)};
    ev(IEL_SEV_CORR, 8'h41, 1'b0, IEL_BUS_PCI, 6'h04, 1'b0, a, 4'h1, o);
    rd(IEL_OFF_IN_ADDR, {32'h0, a[31:2], 2'b00});
    rd(IEL_OFF_IN_TYPE, 64'h1);
    rd(IEL_OFF_OWNER, 64'h8);
    rd(IEL_OFF_OUT_ADDR, o, ~64'h3);
    a = {$random(seed), $random(seed)};
    ev(IEL_SEV_UNC, 8'h42, 1'b0, IEL_BUS_PCIX, 6'h01, 1'b1, a, 4'h4);
    at = in_attr;
    rd(IEL_OFF_IN_ADDR, a);
    rd(IEL_OFF_IN_TYPE, {at, 28'h0, 4'h4});
    rd(IEL_OFF_OWNER, 64'h2);
    rd(IEL_OFF_OUT_ADDR, 64'h0);
    ev(IEL_SEV_CORR, 8'h43, 1'b0, IEL_BUS_PCIX, 6'h02, 1'b1, ~a, 4'h2, o);
    rd(IEL_OFF_IN_ADDR, a);
    rd(IEL_OFF_STATUS, st(8'h42, 6'b001100, 3'b100));
    for (int k = 0; k < 4; k++) begin
      wp();
      ev(IEL_SEV_CORR, 8'h50, 1'b0, IEL_BUS_PCI, 6'h01, 1'b0, 64'h10, 4'h1 << k);
      rd(IEL_OFF_IN_TYPE, 64'h1 << k);
    end
    wp();
    ev(IEL_SEV_CORR, 8'h60, 1'b0, IEL_BUS_AGP, 6'h02);
    rd(IEL_OFF_OWNER, 64'h0, ~64'h2);
    wp();
    ev(IEL_SEV_CORR, 8'h61, 1'b0, IEL_BUS_PCIX, 6'h20);
    rd(IEL_OFF_OWNER, 64'h0, 64'h40);
    wp();
    ev(IEL_SEV_CORR, 8'h62);
    rd(IEL_OFF_OWNER, 64'h0);
    rd(12'h100, 64'h0);
    repeat (4) @(negedge clk);
    cmp(notes.size(), 64'h0, '1);
    report_and_stop();
  end
endmodule : tb_top
